// file: verilog/tcc_timer_unit.sv
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
// Function
// R1 - Counter counts up, wraps all-ones to zero
// R2 - Every wrap sets the overflow flag
// R3 - Overflow interrupt needs run and three enables
// R4 - Software clears the overflow flag itself
// R5 - Software zeroes counter and flag first
// R6 - Sleep counting only in asynchronous external mode
// R7 - Overflow in sleep wakes the device
// R8 - Wake with global enable branches to vector
// R9 - Capture copies counter into the pair
// R10 - Compare match when counter equals pair
// R11 - Special event clears the whole counter
// R12 - Special event never sets overflow flag
// R13 - Pair acts as period in special mode
// R14 - Software keeps counter synchronous for special
// R15 - Counter write beats special event clear
// R16 - Mode zero turns unit off, resets it
// R17 - Falling edge and sixteenth rising capture codes
// R18 - Toggle mode inverts pin, sets flag
// R19 - Clear mode drives pin low, sets flag
// R20 - Soft mode only sets the flag
// R21 - Special mode flags, clears counter, starts conversion
// R22 - PWM mode with ten-bit duty cycle
// R23 - Rising edge and fourth rising capture codes
// R24 - Set mode drives pin high, sets flag
module tcc_timer_unit #(
	parameter int SYNC_STAGES = 2
) (
	input wire logic clk,
	input wire logic nrst,
	input wire tcc_pkg::tcc_bus_req_t bus_req,
	output logic [tcc_pkg::DATA_W-1:0] rd_data,
	input wire logic ext_clk_pin,
	input wire logic capture_pin,
	input wire logic sleep,
	input wire logic adc_enable,
	output logic irq,
	output logic wake,
	output logic vector_req,
	output logic adc_start,
	output logic unit_pin_out,
	output logic unit_pin_oe
);
	import tcc_pkg::*;

	function automatic logic is_compare(input logic [3:0] m);
		return (m == MODE_CMP_TOGGLE) || (m[3:2] == MODE_TOP_CMP);
	endfunction

	function automatic logic is_pwm(input logic [3:0] m);
		return m[3:2] == MODE_TOP_PWM;
	endfunction

	function automatic logic wr_hit(input tcc_bus_req_t r,
		input logic [ADDR_W-1:0] off);
		return r.wr && (r.addr == off);
	endfunction

	logic [1:0] pin_sync;
	logic ext_q, cap_q, next_ext, next_cap;
	logic [CNT_W-1:0] counter, next_counter;
	logic [2:0] pre_cnt, next_pre, pre_limit;
	tcc_ctl_t ctl, next_ctl;
	logic [DATA_W-1:0] flags, next_flags, irq_en, next_irq_en;
	logic [DATA_W-1:0] core_ctl, next_core_ctl, next_rd;
	tcc_unit_ctl_t unit_ctl, next_unit_ctl;
	logic [CNT_W-1:0] pair, next_pair;
	logic pin_q, next_pin, equal_q, next_equal;
	logic [3:0] edge_cnt, next_edge, edge_last, mode;
	logic next_wake, next_vector, next_adc;
	logic ext_rise, cap_rise, cap_fall, async_mode, can_run, step, tick;
	logic equal, match_evt, special, wr_cnt, ovf_evt, capture_evt;
	logic pwm_level, global_irq_enable, peripheral_irq_enable;

	initial
	begin
		if (SYNC_STAGES < 2)
			$error("SYNC_STAGES must be at least two");
	end

	tcc_sync #(
		.WIDTH(2),
		.STAGES(SYNC_STAGES)
	) u_sync (
		.clk(clk),
		.nrst(nrst),
		.din({ext_clk_pin, capture_pin}),
		.dout(pin_sync)
	);

	// Events of this cycle
	always_comb
	begin
		mode = unit_ctl.unit_mode_field;
		global_irq_enable = core_ctl[CORE_GIE_BIT];
		peripheral_irq_enable = core_ctl[CORE_PERIPHERAL_IRQ_ENABLE_BIT];
		next_ext = pin_sync[1];
		next_cap = pin_sync[0];
		ext_rise = pin_sync[1] && !ext_q;
		cap_rise = pin_sync[0] && !cap_q;
		cap_fall = !pin_sync[0] && cap_q;
		async_mode = (ctl.counter_clock_select == CLK_SEL_EXT)
			&& ctl.sync_bypass;
		can_run = !sleep || async_mode; // R6
		step = ctl.counter_run && can_run
			&& (ctl.counter_clock_select[1] ? ext_rise : 1'b1);
		pre_limit = 3'((4'h1 << ctl.prescale) - 4'h1);
		tick = step && (pre_cnt == pre_limit);
		equal = counter == pair;
		match_evt = is_compare(mode) && equal && !equal_q; // R10
		special = match_evt && (mode == MODE_CMP_SPECIAL); // R13
		wr_cnt = wr_hit(bus_req, OFF_CNT_LO)
			|| wr_hit(bus_req, OFF_CNT_HI);
		ovf_evt = tick && (counter == CNT_ALL_ONES)
			&& !special && !wr_cnt; // R12
		edge_last = (mode == MODE_CAP_RISE4) ? EDGE_LAST4 : EDGE_LAST16;
		case (mode)
			MODE_CAP_FALL: capture_evt = cap_fall; // R17
			MODE_CAP_RISE: capture_evt = cap_rise; // R23
			MODE_CAP_RISE4, MODE_CAP_RISE16:
				capture_evt = cap_rise && (edge_cnt == edge_last);
			default: capture_evt = 1'b0;
		endcase
		pwm_level = {pair[7:0], unit_ctl.duty_low_bits}
			> counter[9:0]; // R22
	end

	// Counter and prescaler
	always_comb
	begin
		next_counter = counter;
		next_pre = pre_cnt;
		if (step)
			next_pre = tick ? 3'h0 : pre_cnt + 3'h1;
		if (wr_cnt)
		begin
			next_pre = 3'h0;
			if (bus_req.addr == OFF_CNT_LO)
				next_counter[7:0] = bus_req.wdata; // R15
			else
				next_counter[15:8] = bus_req.wdata; // R15
		end
		else if (special)
			next_counter = RST_WORD; // R11
		else if (tick)
			next_counter = counter + 16'h0001; // R1
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			counter <= RST_WORD;
			pre_cnt <= 3'h0;
			ext_q <= 1'b0;
			cap_q <= 1'b0;
		end
		else
		begin
			counter <= next_counter;
			pre_cnt <= next_pre;
			ext_q <= next_ext;
			cap_q <= next_cap;
		end
	end

	// Control, flag and enable registers
	always_comb
	begin
		next_ctl = ctl;
		next_flags = flags;
		next_irq_en = irq_en;
		next_core_ctl = core_ctl;
		if (wr_hit(bus_req, OFF_CNT_CTL))
			next_ctl = bus_req.wdata & CTL_WR_MASK;
		if (wr_hit(bus_req, OFF_IRQ_EN))
			next_irq_en = bus_req.wdata;
		if (wr_hit(bus_req, OFF_CORE_CTL))
			next_core_ctl = bus_req.wdata;
		if (wr_hit(bus_req, OFF_FLAGS))
			next_flags = bus_req.wdata; // R4
		if (ovf_evt)
			next_flags[FLAG_OVF_BIT] = 1'b1; // R2
		if (match_evt || capture_evt)
			next_flags[FLAG_UNIT_BIT] = 1'b1; // R18 R19 R20 R21 R24
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			ctl <= RST_BYTE;
			flags <= RST_BYTE;
			irq_en <= RST_BYTE;
			core_ctl <= RST_BYTE;
		end
		else
		begin
			ctl <= next_ctl;
			flags <= next_flags;
			irq_en <= next_irq_en;
			core_ctl <= next_core_ctl;
		end
	end

	// Capture/compare/PWM unit
	always_comb
	begin
		next_unit_ctl = unit_ctl;
		next_pair = pair;
		next_pin = pin_q;
		next_edge = edge_cnt;
		next_equal = equal && is_compare(mode);
		if (wr_hit(bus_req, OFF_UNIT_CTL))
		begin
			next_unit_ctl = bus_req.wdata & UNIT_WR_MASK;
			next_edge = 4'h0;
		end
		else if (cap_rise && ((mode == MODE_CAP_RISE4)
			|| (mode == MODE_CAP_RISE16)))
			next_edge = (edge_cnt == edge_last) ? 4'h0 : edge_cnt + 4'h1;
		if (wr_hit(bus_req, OFF_PAIR_LO))
			next_pair[7:0] = bus_req.wdata;
		if (wr_hit(bus_req, OFF_PAIR_HI))
			next_pair[15:8] = bus_req.wdata;
		if (capture_evt)
			next_pair = counter; // R9
		if (is_pwm(mode))
			next_pin = pwm_level; // R22
		else if (match_evt)
		begin
			case (mode)
				MODE_CMP_TOGGLE: next_pin = !pin_q; // R18
				MODE_CMP_SET: next_pin = 1'b1; // R24
				MODE_CMP_CLEAR: next_pin = 1'b0; // R19
				default: next_pin = pin_q; // R20 R21
			endcase
		end
		if (mode == MODE_OFF)
		begin
			next_pin = 1'b0; // R16
			next_edge = 4'h0;
			next_equal = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			unit_ctl <= RST_BYTE;
			pair <= RST_WORD;
			pin_q <= 1'b0;
			edge_cnt <= 4'h0;
			equal_q <= 1'b0;
		end
		else
		begin
			unit_ctl <= next_unit_ctl;
			pair <= next_pair;
			pin_q <= next_pin;
			edge_cnt <= next_edge;
			equal_q <= next_equal;
		end
	end

	// Wake, vector, conversion start and read data
	always_comb
	begin
		next_wake = sleep && ovf_evt && ctl.counter_run
			&& irq_en[FLAG_OVF_BIT] && peripheral_irq_enable && ctl.sync_bypass; // R7
		next_vector = next_wake && global_irq_enable; // R8
		next_adc = special && adc_enable; // R21
		next_rd = RST_BYTE;
		if (bus_req.rd)
		begin
			case (bus_req.addr)
				OFF_CNT_LO: next_rd = counter[7:0];
				OFF_CNT_HI: next_rd = counter[15:8];
				OFF_CNT_CTL: next_rd = ctl;
				OFF_PAIR_LO: next_rd = pair[7:0];
				OFF_PAIR_HI: next_rd = pair[15:8];
				OFF_UNIT_CTL: next_rd = unit_ctl;
				OFF_FLAGS: next_rd = flags;
				OFF_IRQ_EN: next_rd = irq_en;
				OFF_CORE_CTL: next_rd = core_ctl;
				default: next_rd = RST_BYTE;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			wake <= 1'b0;
			vector_req <= 1'b0;
			adc_start <= 1'b0;
			rd_data <= RST_BYTE;
		end
		else
		begin
			wake <= next_wake;
			vector_req <= next_vector;
			adc_start <= next_adc;
			rd_data <= next_rd;
		end
	end

	assign irq = global_irq_enable && peripheral_irq_enable && ((flags[FLAG_OVF_BIT]
		&& irq_en[FLAG_OVF_BIT] && ctl.counter_run) // R3
		|| (flags[FLAG_UNIT_BIT] && irq_en[FLAG_UNIT_BIT]));
	assign unit_pin_out = pin_q;
	assign unit_pin_oe = is_compare(mode) || is_pwm(mode);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	property p_wrap;
		tick && counter == CNT_ALL_ONES && !wr_cnt && !special
			|=> counter == RST_WORD && flags[FLAG_OVF_BIT];
	endproperty
	a_wrap: assert property (p_wrap) else $error("no wrap"); // R1

	property p_ovf_flag;
		ovf_evt |=> flags[FLAG_OVF_BIT] && counter == RST_WORD;
	endproperty
	a_ovf_flag: assert property (p_ovf_flag) else $error("flag"); // R2

	property p_irq_gate;
		!ctl.counter_run && !flags[FLAG_UNIT_BIT] |-> !irq;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq"); // R3

	property p_sleep_hold;
		sleep && !async_mode && !wr_cnt && !special |=> $stable(counter);
	endproperty
	a_sleep_hold: assert property (p_sleep_hold)
		else $error("counted in sleep"); // R6

	property p_wake;
		sleep && ovf_evt && ctl.sync_bypass && irq_en[FLAG_OVF_BIT]
			&& peripheral_irq_enable |=> wake;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake"); // R7

	property p_vector;
		vector_req |-> wake && $past(global_irq_enable);
	endproperty
	a_vector: assert property (p_vector) else $error("vector"); // R8

	property p_capture;
		capture_evt |=> pair == $past(counter) && flags[FLAG_UNIT_BIT];
	endproperty
	a_capture: assert property (p_capture) else $error("capture"); // R9

	property p_match;
		is_compare(mode) && equal && !equal_q |-> match_evt ##1 equal_q;
	endproperty
	a_match: assert property (p_match) else $error("match"); // R10

	property p_special;
		special && !wr_cnt |=> counter == RST_WORD
			&& flags[FLAG_UNIT_BIT] && adc_start == $past(adc_enable);
	endproperty
	a_special: assert property (p_special) else $error("special"); // R11

	property p_special_no_ovf;
		special && !flags[FLAG_OVF_BIT] && !wr_hit(bus_req, OFF_FLAGS)
			|=> !flags[FLAG_OVF_BIT];
	endproperty
	a_special_no_ovf: assert property (p_special_no_ovf)
		else $error("overflow on special"); // R12

	property p_write_wins;
		special && wr_hit(bus_req, OFF_CNT_LO)
			|=> counter[7:0] == $past(bus_req.wdata);
	endproperty
	a_write_wins: assert property (p_write_wins)
		else $error("write lost"); // R15

	property p_off;
		mode == MODE_OFF |=> !pin_q && edge_cnt == 4'h0;
	endproperty
	a_off: assert property (p_off) else $error("off"); // R16

	property p_div16;
		mode == MODE_CAP_RISE16 && capture_evt |-> edge_cnt == EDGE_LAST16;
	endproperty
	a_div16: assert property (p_div16) else $error("div16"); // R17

	property p_toggle;
		match_evt && mode == MODE_CMP_TOGGLE |=> pin_q != $past(pin_q);
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle"); // R18

	property p_clear;
		match_evt && mode == MODE_CMP_CLEAR |=> !pin_q;
	endproperty
	a_clear: assert property (p_clear) else $error("clear"); // R19

	property p_soft;
		match_evt && mode == MODE_CMP_SOFT
			|=> $stable(pin_q) && flags[FLAG_UNIT_BIT];
	endproperty
	a_soft: assert property (p_soft) else $error("soft"); // R20

	property p_pwm;
		is_pwm(mode) |=> pin_q == $past(pwm_level);
	endproperty
	a_pwm: assert property (p_pwm) else $error("pwm"); // R22

	property p_rise;
		mode == MODE_CAP_RISE && cap_rise |-> capture_evt;
	endproperty
	a_rise: assert property (p_rise) else $error("rise"); // R23

	property p_set;
		match_evt && mode == MODE_CMP_SET |=> pin_q;
	endproperty
	a_set: assert property (p_set) else $error("set"); // R24

	c_ovf: cover property (ovf_evt);
	c_special: cover property (special ##1 adc_start);
	c_capture: cover property (capture_evt && mode == MODE_CAP_RISE16);
	c_wake: cover property (wake && vector_req);
endmodule

// file: include/tcc_pkg.sv
package tcc_pkg;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int CNT_W = 16;

	// Register offsets
	localparam logic [ADDR_W-1:0] OFF_CNT_LO = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_CNT_HI = 4'h1;
	localparam logic [ADDR_W-1:0] OFF_CNT_CTL = 4'h2;
	localparam logic [ADDR_W-1:0] OFF_PAIR_LO = 4'h3;
	localparam logic [ADDR_W-1:0] OFF_PAIR_HI = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_UNIT_CTL = 4'h5;
	localparam logic [ADDR_W-1:0] OFF_FLAGS = 4'h6;
	localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 4'h7;
	localparam logic [ADDR_W-1:0] OFF_CORE_CTL = 4'h8;

	// Values after reset, and the all-ones counter value
	localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
	localparam logic [CNT_W-1:0] RST_WORD = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ALL_ONES = 16'hffff;

	// Writable bit masks
	localparam logic [DATA_W-1:0] CTL_WR_MASK = 8'hfd;
	localparam logic [DATA_W-1:0] UNIT_WR_MASK = 8'h3f;

	// Field positions
	localparam int FLAG_OVF_BIT = 0;
	localparam int FLAG_UNIT_BIT = 2;
	localparam int CORE_GIE_BIT = 7;
	localparam int CORE_PERIPHERAL_IRQ_ENABLE_BIT = 6;

	// Counter clock sources
	localparam logic [1:0] CLK_SEL_EXT = 2'h2;

	// Unit modes
	localparam logic [3:0] MODE_OFF = 4'h0;
	localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
	localparam logic [3:0] MODE_CAP_FALL = 4'h4;
	localparam logic [3:0] MODE_CAP_RISE = 4'h5;
	localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
	localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
	localparam logic [3:0] MODE_CMP_SET = 4'h8;
	localparam logic [3:0] MODE_CMP_CLEAR = 4'h9;
	localparam logic [3:0] MODE_CMP_SOFT = 4'ha;
	localparam logic [3:0] MODE_CMP_SPECIAL = 4'hb;
	localparam logic [1:0] MODE_TOP_CAP = 2'h1;
	localparam logic [1:0] MODE_TOP_CMP = 2'h2;
	localparam logic [1:0] MODE_TOP_PWM = 2'h3;

	// Last edge count of the divided capture modes
	localparam logic [3:0] EDGE_LAST4 = 4'h3;
	localparam logic [3:0] EDGE_LAST16 = 4'hf;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} tcc_bus_req_t;

	typedef struct packed {
		logic [1:0] counter_clock_select;
		logic [1:0] prescale;
		logic low_freq_osc_enable;
		logic sync_bypass;
		logic unused;
		logic counter_run;
	} tcc_ctl_t;

	typedef struct packed {
		logic [1:0] unused;
		logic [1:0] duty_low_bits;
		logic [3:0] unit_mode_field;
	} tcc_unit_ctl_t;

endpackage

// file: verilog/tcc_sync.sv
`timescale 1ns/1ps
module tcc_sync #(
	parameter int WIDTH = 2,
	parameter int STAGES = 2
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] stage [STAGES];
	logic [WIDTH-1:0] next_stage [STAGES];

	initial
	begin
		if (STAGES < 2)
			$error("tcc_sync needs at least two stages");
	end

	always_comb
	begin
		next_stage[0] = din;
		for (int i = 1; i < STAGES; i++)
			next_stage[i] = stage[i-1];
	end

	always_ff @(posedge clk)
	begin
		for (int i = 0; i < STAGES; i++)
		begin
			if (!nrst)
				stage[i] <= '0;
			else
				stage[i] <= next_stage[i];
		end
	end

	assign dout = stage[STAGES-1];
endmodule

// file: verif/tcc_timer_unit_tb.sv
`timescale 1ns/1ps
module tcc_timer_unit_tb;
	import tcc_pkg::*;
	logic clk;
	logic nrst;
	tcc_bus_req_t bus_req;
	logic [DATA_W-1:0] rd_data;
	logic ext_clk_pin;
	logic capture_pin;
	logic sleep;
	logic adc_enable;
	logic irq;
	logic wake;
	logic vector_req;
	logic adc_start;
	logic unit_pin_out;
	logic unit_pin_oe;
	int fails = 0;
	int n_compared = 0;
	int n_wake;
	int n_vec;
	int n_adc;

	tcc_timer_unit dut_u (
		.clk(clk),
		.nrst(nrst),
		.bus_req(bus_req),
		.rd_data(rd_data),
		.ext_clk_pin(ext_clk_pin),
		.capture_pin(capture_pin),
		.sleep(sleep),
		.adc_enable(adc_enable),
		.irq(irq),
		.wake(wake),
		.vector_req(vector_req),
		.adc_start(adc_start),
		.unit_pin_out(unit_pin_out),
		.unit_pin_oe(unit_pin_oe)
	);

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] g, input logic [15:0] e,
		input string w);
		n_compared++;
		if (g !== e)
		begin
			fails++;
			$display("mismatch at %0t: %s got %h want %h", $time, w, g, e);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		bus_req <= '0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge clk);
		bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		bus_req <= '0;
		#1;
		d = rd_data;
	endtask

	task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
		input string w);
		logic [DATA_W-1:0] d;
		rd(a, d);
		check(16'(d), 16'(e), w);
	endtask

	// Idle cycles; optional external clock toggling, pulse counting
	task automatic cyc(input int n, input bit tog);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk);
			if (tog && i % 4 == 0)
				ext_clk_pin <= ~ext_clk_pin;
			#1;
			n_wake += int'(wake === 1'b1);
			n_vec += int'(vector_req === 1'b1);
			n_adc += int'(adc_start === 1'b1);
		end
	endtask

	task automatic zero();
		wr(OFF_CNT_CTL, 8'h00);
		wr(OFF_CNT_LO, 8'h00);
		wr(OFF_CNT_HI, 8'h00);
		wr(OFF_FLAGS, 8'h00);
	endtask

	task automatic t_regs();
		for (int a = 0; a < 9; a++)
			rchk(a[ADDR_W-1:0], RST_BYTE, "reset value");
		wr(OFF_CNT_CTL, 8'hff);
		rchk(OFF_CNT_CTL, CTL_WR_MASK, "ctl reserved bit");
		wr(OFF_UNIT_CTL, 8'hff);
		rchk(OFF_UNIT_CTL, UNIT_WR_MASK, "unit reserved bits");
		wr(OFF_UNIT_CTL, 8'h00);
		wr(4'hf, 8'h5a);
		rchk(4'hf, 8'h00, "unmapped read");
		$display("test regs done");
	endtask

	task automatic t_wrap();
		zero();
		wr(OFF_CNT_LO, 8'hf8);
		wr(OFF_CNT_HI, 8'hff);
		wr(OFF_IRQ_EN, 8'h01);
		wr(OFF_CORE_CTL, 8'h40);
		wr(OFF_CNT_CTL, 8'h01);
		cyc(20, 0);
		check(16'(irq), 16'h0000, "irq without global");
		wr(OFF_CORE_CTL, 8'hc0);
		cyc(1, 0);
		check(16'(irq), 16'h0001, "irq all enables");
		wr(OFF_CNT_CTL, 8'h00);
		cyc(1, 0);
		check(16'(irq), 16'h0000, "irq run off");
		rchk(OFF_CNT_HI, 8'h00, "wrap to zero");
		cyc(4, 0);
		rchk(OFF_FLAGS, 8'h01, "overflow flag held");
		wr(OFF_FLAGS, 8'h00);
		rchk(OFF_FLAGS, 8'h00, "flag cleared");
		wr(OFF_CORE_CTL, 8'h00);
		$display("test wrap done");
	endtask

	task automatic t_sleep();
		zero();
		wr(OFF_CNT_LO, 8'h10);
		sleep <= 1'b1;
		wr(OFF_CNT_CTL, 8'h01);
		cyc(10, 0);
		rchk(OFF_CNT_LO, 8'h10, "frozen in sleep");
		wr(OFF_IRQ_EN, 8'h01);
		for (int g = 0; g < 2; g++)
		begin
			zero();
			wr(OFF_CNT_LO, 8'hfe);
			wr(OFF_CNT_HI, 8'hff);
			wr(OFF_CORE_CTL, g ? 8'hc0 : 8'h40);
			wr(OFF_CNT_CTL, 8'h85);
			n_wake = 0;
			n_vec = 0;
			cyc(40, 1);
			check(16'(n_wake), 16'h0001, "wake pulses");
			check(16'(n_vec), 16'(g), "vector pulses");
		end
		sleep <= 1'b0;
		zero();
		wr(OFF_CORE_CTL, 8'h00);
		wr(OFF_IRQ_EN, 8'h00);
		$display("test sleep done");
	endtask

	task automatic t_cmp();
		logic [3:0] m [4] = '{MODE_CMP_TOGGLE, MODE_CMP_CLEAR, MODE_CMP_SOFT,
			MODE_CMP_SET};
		logic p [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
		wr(OFF_PAIR_LO, 8'h10);
		wr(OFF_PAIR_HI, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			zero();
			wr(OFF_UNIT_CTL, {4'h0, m[i]});
			wr(OFF_CNT_CTL, 8'h01);
			cyc(30, 0);
			check(16'(unit_pin_out), 16'(p[i]), "compare pin");
			check(16'(unit_pin_oe), 16'h0001, "compare enable");
			rchk(OFF_FLAGS, 8'h04, "compare flag");
		end
		wr(OFF_UNIT_CTL, {4'h0, MODE_OFF});
		cyc(2, 0);
		check(16'(unit_pin_out), 16'h0000, "off pin");
		check(16'(unit_pin_oe), 16'h0000, "off enable");
		$display("test compare done");
	endtask

	task automatic t_special();
		logic [DATA_W-1:0] d;
		for (int e = 1; e >= 0; e--)
		begin
			zero();
			adc_enable <= e[0];
			wr(OFF_UNIT_CTL, {4'h0, MODE_CMP_SPECIAL});
			wr(OFF_CNT_CTL, 8'h01);
			n_adc = 0;
			cyc(60, 0);
			check(16'(n_adc), e ? 16'h0003 : 16'h0000, "adc starts");
			wr(OFF_CNT_CTL, 8'h00);
			rchk(OFF_FLAGS, 8'h04, "no overflow flag");
			rchk(OFF_CNT_HI, 8'h00, "counter cleared");
			rd(OFF_CNT_LO, d);
			check(16'(d <= 8'h10), 16'h0001, "period bound");
			check(16'(unit_pin_out), 16'h0000, "pin untouched");
		end
		adc_enable <= 1'b0;
		$display("test special done");
	endtask

	task automatic t_edge();
		zero();
		wr(OFF_UNIT_CTL, {4'h0, MODE_CMP_SPECIAL});
		wr(OFF_PAIR_LO, 8'hff);
		wr(OFF_PAIR_HI, 8'hff);
		wr(OFF_CNT_LO, 8'hf8);
		wr(OFF_CNT_HI, 8'hff);
		wr(OFF_CNT_CTL, 8'h01);
		cyc(20, 0);
		wr(OFF_CNT_CTL, 8'h00);
		rchk(OFF_FLAGS, 8'h04, "special at all ones");
		wr(OFF_CNT_HI, 8'hff);
		// Second write lands in the match cycle of the first
		@(posedge clk);
		bus_req <= '{wr: 1'b1, rd: 1'b0, addr: OFF_CNT_LO,
			wdata: 8'hff};
		@(posedge clk);
		bus_req <= '{wr: 1'b1, rd: 1'b0, addr: OFF_CNT_LO,
			wdata: 8'h33};
		@(posedge clk);
		bus_req <= '0;
		rchk(OFF_CNT_LO, 8'h33, "write beats clear low");
		rchk(OFF_CNT_HI, 8'hff, "write beats clear high");
		$display("test edge done");
	endtask

	task automatic cap(input logic [3:0] m, input int n, input logic f);
		capture_pin <= 1'b0;
		cyc(8, 0);
		zero();
		wr(OFF_PAIR_LO, 8'hff);
		wr(OFF_PAIR_HI, 8'hff);
		wr(OFF_UNIT_CTL, {4'h0, m});
		wr(OFF_CNT_CTL, 8'h01);
		for (int i = 0; i < n; i++)
		begin
			capture_pin <= 1'b1;
			cyc(4, 0);
			if (i < n - 1)
			begin
				capture_pin <= 1'b0;
				cyc(4, 0);
			end
		end
		cyc(8, 0);
		rchk(OFF_FLAGS, {5'h00, f, 2'h0}, "capture flag");
		rchk(OFF_PAIR_HI, f ? 8'h00 : 8'hff, "capture value");
	endtask

	task automatic t_pwm();
		zero();
		wr(OFF_PAIR_LO, 8'h40);
		wr(OFF_UNIT_CTL, 8'h3c);
		wr(OFF_CNT_LO, 8'h02);
		wr(OFF_CNT_HI, 8'h01);
		cyc(3, 0);
		check(16'(unit_pin_out), 16'h0001, "pwm below duty");
		check(16'(unit_pin_oe), 16'h0001, "pwm enable");
		wr(OFF_CNT_LO, 8'h03);
		cyc(3, 0);
		check(16'(unit_pin_out), 16'h0000, "pwm at duty");
		wr(OFF_UNIT_CTL, 8'h00);
		$display("test pwm done");
	endtask

	initial
	begin
		repeat (20000) @(posedge clk);
		fails++;
		$display("mismatch at %0t: watchdog expired", $time);
		complete_run();
	end

	initial
	begin
		nrst = 1'b0;
		bus_req = '0;
		ext_clk_pin = 1'b0;
		capture_pin = 1'b0;
		sleep = 1'b0;
		adc_enable = 1'b0;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		t_regs();
		t_wrap();
		t_sleep();
		t_cmp();
		t_special();
		t_edge();
		cap(MODE_CAP_FALL, 1, 1'b0);
		cap(MODE_CAP_FALL, 2, 1'b1);
		cap(MODE_CAP_RISE, 1, 1'b1);
		cap(MODE_CAP_RISE4, 3, 1'b0);
		cap(MODE_CAP_RISE4, 4, 1'b1);
		cap(MODE_CAP_RISE16, 15, 1'b0);
		cap(MODE_CAP_RISE16, 16, 1'b1);
		$display("test capture done");
		t_pwm();
		complete_run();
	end
endmodule
